/* hdl/bgrb_pkg.sv */
// package of register offsets, field positions and reset values for the graphics register bank
package bgrb_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   // register addresses
   localparam logic [7:0] ADR_SERIAL_STRAPS = 8'h30;
   localparam logic [7:0] ADR_X_LO = 8'h40;
   localparam logic [7:0] ADR_X_HI = 8'h41;
   localparam logic [7:0] ADR_Y_LO = 8'h42;
   localparam logic [7:0] ADR_Y_HI = 8'h43;
   localparam logic [7:0] ADR_COORD_STEP = 8'h60;
   localparam logic [7:0] ADR_PLANE_COMMAND = 8'h62;
   localparam logic [7:0] ADR_PAN_FINE = 8'h64;
   localparam logic [7:0] ADR_PAN_COARSE = 8'h65;
   localparam logic [7:0] ADR_SCROLL_TOP_ROW = 8'h66;
   localparam logic [7:0] ADR_MAGNIFY_FACTORS = 8'h67;
   localparam logic [7:0] ADR_PIXEL_DATA = 8'h68;
   localparam logic [7:0] ADR_BOARD_STATUS = 8'ha0;
   localparam logic [7:0] ADR_PRINTER_OUT = 8'ha1;
   localparam logic [7:0] ADR_TERMINAL_INPUT = 8'ha2;
   localparam logic [7:0] ADR_MEMORY_WRITE_GATE = 8'ha3;
   // serial strap fields
   localparam int unsigned SS_WORD7 = 0;
   localparam int unsigned SS_ODD = 1;
   localparam int unsigned SS_ONE_STOP = 2;
   localparam int unsigned SS_PAR_ON = 3;
   // coordinate step fields
   localparam int unsigned CS_X_UP = 0;
   localparam int unsigned CS_Y_UP = 1;
   localparam int unsigned CS_X_DOWN = 2;
   localparam int unsigned CS_Y_DOWN = 3;
   localparam int unsigned CS_NO_DOT = 4;
   // plane command fields
   localparam int unsigned PC_FILL0 = 0;
   localparam int unsigned PC_FILL1 = 1;
   localparam int unsigned PC_OFF0 = 4;
   localparam int unsigned PC_OFF1 = 5;
   localparam int unsigned PC_FMT_LO = 6;
   localparam int unsigned PC_FMT_HI = 7;
   // pixel data fields
   localparam int unsigned PD_ODD = 5;
   localparam int unsigned PD_COMP = 6;
   localparam int unsigned PD_PAR_ON = 7;
   // board status fields
   localparam int unsigned BS_BUSY = 0;
   localparam int unsigned BS_VBLANK_N = 1;
   localparam int unsigned BS_WORD7 = 2;
   localparam int unsigned BS_INPUT = 7;
   // write gate field
   localparam int unsigned WG_ENABLE = 0;
   // display formats, command bits seven and six
   localparam logic [1:0] FMT_1219X240_BW = 2'h0;
   localparam logic [1:0] FMT_610X240_OR = 2'h2;
   localparam logic [1:0] FMT_610X480_BW = 2'h1;
   localparam logic [1:0] FMT_610X240_GREY = 2'h3;
   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [15:0] RST_COORD = 16'h0000;
endpackage : bgrb_pkg

/* hdl/bgrb_register_bank.sv */
// register bank of the two-plane bitmap graphics board, with flip-flop display memory
`timescale 1ns/1ps
module bgrb_register_bank #(
   parameter int unsigned PIX_X_W = 4,
   parameter int unsigned PIX_Y_W = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic printer_busy,
   input wire logic vblank_n,
   input wire logic term_strobe,
   input wire logic [7:0] term_data,
   input wire logic [PIX_X_W-1:0] vid_x,
   input wire logic [PIX_Y_W-1:0] vid_y,
   output logic [1:0] vid_pixel,
   output logic [1:0] display_format,
   output logic [7:0] pan_fine,
   output logic [7:0] pan_coarse,
   output logic [7:0] scroll_top_row,
   output logic [7:0] magnify_factors,
   output logic [7:0] printer_data,
   output logic printer_load,
   output logic serial_word7,
   output logic serial_odd,
   output logic serial_one_stop,
   output logic serial_parity_on
);
   localparam int unsigned NPIX = 1 << (PIX_X_W + PIX_Y_W);
   localparam int unsigned IDX_W = PIX_X_W + PIX_Y_W;

   typedef struct packed {
      logic [NPIX-1:0][1:0] mem;
      logic [15:0] x;
      logic [15:0] y;
      logic [7:0] straps;
      logic [7:0] cmd;
      logic [7:0] pan_lo;
      logic [7:0] pan_hi;
      logic [7:0] scroll;
      logic [7:0] zoom;
      logic [1:0] data;
      logic wen;
      logic [7:0] prn;
      logic prn_load;
      logic [7:0] tin;
      logic tin_flag;
      logic [7:0] rdata;
      logic [1:0] vpix;
      logic busy_s1;
      logic busy_s2;
      logic vb_s1;
      logic vb_s2;
      logic ts_s1;
      logic ts_s2;
      logic ts_s3;
      logic [7:0] td_s1;
      logic [7:0] td_s2;
   } bgrb_state_t;

   bgrb_state_t st_ff;
   bgrb_state_t nxt_st;

   // pixel index from coordinates, low bits of each
   function automatic logic [IDX_W-1:0] bgrb_idx(input logic [15:0] xc, input logic [15:0] yc);
      bgrb_idx = {yc[PIX_Y_W-1:0], xc[PIX_X_W-1:0]};
   endfunction : bgrb_idx

   logic wr_hit_step;
   logic [15:0] step_x;
   logic [15:0] step_y;
   logic term_rise;

   // register writes, vector steps, pixel operations, reads and synchronisers
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.prn_load = 1'b0;
      // pin inputs pass two flip-flops, the terminal strobe a third for its rise
      nxt_st.busy_s1 = printer_busy;
      nxt_st.busy_s2 = st_ff.busy_s1;
      nxt_st.vb_s1 = vblank_n;
      nxt_st.vb_s2 = st_ff.vb_s1;
      nxt_st.ts_s1 = term_strobe;
      nxt_st.ts_s2 = st_ff.ts_s1;
      nxt_st.ts_s3 = st_ff.ts_s2;
      nxt_st.td_s1 = term_data;
      nxt_st.td_s2 = st_ff.td_s1;
      term_rise = st_ff.ts_s2 & ~st_ff.ts_s3;
      wr_hit_step = io_wr && (io_addr == bgrb_pkg::ADR_COORD_STEP);
      step_x = st_ff.x + 16'(io_wdata[bgrb_pkg::CS_X_UP]) -
         16'(io_wdata[bgrb_pkg::CS_X_DOWN]);
      step_y = st_ff.y + 16'(io_wdata[bgrb_pkg::CS_Y_UP]) -
         16'(io_wdata[bgrb_pkg::CS_Y_DOWN]);
      // write decode, every register but board status and terminal input loads on the write strobe
      if (io_wr)
      begin
         unique case (io_addr)
            bgrb_pkg::ADR_SERIAL_STRAPS: nxt_st.straps = io_wdata;
            bgrb_pkg::ADR_X_LO: nxt_st.x[7:0] = io_wdata;
            bgrb_pkg::ADR_X_HI: nxt_st.x[15:8] = io_wdata;
            bgrb_pkg::ADR_Y_LO: nxt_st.y[7:0] = io_wdata;
            bgrb_pkg::ADR_Y_HI: nxt_st.y[15:8] = io_wdata;
            bgrb_pkg::ADR_COORD_STEP:
            begin
               nxt_st.x = step_x;
               nxt_st.y = step_y;
               if (!io_wdata[bgrb_pkg::CS_NO_DOT] && st_ff.wen)
                  nxt_st.mem[bgrb_idx(step_x, step_y)] = st_ff.data;
            end
            bgrb_pkg::ADR_PLANE_COMMAND:
            begin
               nxt_st.cmd = io_wdata;
               for (int i = 0; i < NPIX; i++)
               begin
                  if (io_wdata[bgrb_pkg::PC_FILL0] && st_ff.wen)
                     nxt_st.mem[i][0] = st_ff.data[0];
                  if (io_wdata[bgrb_pkg::PC_FILL1] && st_ff.wen)
                     nxt_st.mem[i][1] = st_ff.data[1];
               end
            end
            bgrb_pkg::ADR_PAN_FINE: nxt_st.pan_lo = io_wdata;
            bgrb_pkg::ADR_PAN_COARSE: nxt_st.pan_hi = io_wdata;
            bgrb_pkg::ADR_SCROLL_TOP_ROW: nxt_st.scroll = io_wdata;
            bgrb_pkg::ADR_MAGNIFY_FACTORS: nxt_st.zoom = io_wdata;
            bgrb_pkg::ADR_PIXEL_DATA:
            begin
               nxt_st.data = io_wdata[1:0];
               if (io_wdata[bgrb_pkg::PD_COMP] && st_ff.wen)
                  nxt_st.mem[bgrb_idx(st_ff.x, st_ff.y)] =
                     ~st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)];
            end
            bgrb_pkg::ADR_PRINTER_OUT:
            begin
               nxt_st.prn = io_wdata;
               nxt_st.prn_load = 1'b1;
            end
            bgrb_pkg::ADR_MEMORY_WRITE_GATE: nxt_st.wen = io_wdata[bgrb_pkg::WG_ENABLE];
            default: ;
         endcase
      end
      // read decode, answer stands from the edge after the read strobe
      if (io_rd)
      begin
         unique case (io_addr)
            bgrb_pkg::ADR_X_LO: nxt_st.rdata = st_ff.x[7:0];
            bgrb_pkg::ADR_X_HI: nxt_st.rdata = st_ff.x[15:8];
            bgrb_pkg::ADR_Y_LO: nxt_st.rdata = st_ff.y[7:0];
            bgrb_pkg::ADR_Y_HI: nxt_st.rdata = st_ff.y[15:8];
            bgrb_pkg::ADR_PIXEL_DATA:
               nxt_st.rdata = {st_ff.straps[bgrb_pkg::SS_PAR_ON],
                  st_ff.straps[bgrb_pkg::SS_ONE_STOP],
                  st_ff.straps[bgrb_pkg::SS_ODD], 3'h0,
                  st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)]};
            bgrb_pkg::ADR_BOARD_STATUS:
               nxt_st.rdata = {st_ff.tin_flag, 4'h0,
                  st_ff.straps[bgrb_pkg::SS_WORD7],
                  st_ff.vb_s2, st_ff.busy_s2};
            bgrb_pkg::ADR_TERMINAL_INPUT:
            begin
               nxt_st.rdata = st_ff.tin;
               nxt_st.tin_flag = 1'b0;
            end
            default: nxt_st.rdata = bgrb_pkg::RST_REG8;
         endcase
      end
      // a byte deposited in the same cycle as the read still sets the flag
      if (term_rise)
      begin
         nxt_st.tin = st_ff.td_s2;
         nxt_st.tin_flag = 1'b1;
      end
      // video pixel with per-plane blanking
      nxt_st.vpix = st_ff.mem[{vid_y, vid_x}] &
         ~{st_ff.cmd[bgrb_pkg::PC_OFF1], st_ff.cmd[bgrb_pkg::PC_OFF0]};
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // outputs straight from flip-flops
   assign io_rdata = st_ff.rdata;
   assign vid_pixel = st_ff.vpix;
   assign display_format = {st_ff.cmd[bgrb_pkg::PC_FMT_HI], st_ff.cmd[bgrb_pkg::PC_FMT_LO]};
   assign pan_fine = st_ff.pan_lo;
   assign pan_coarse = st_ff.pan_hi;
   assign scroll_top_row = st_ff.scroll;
   assign magnify_factors = st_ff.zoom;
   assign printer_data = st_ff.prn;
   assign printer_load = st_ff.prn_load;
   assign serial_word7 = st_ff.straps[bgrb_pkg::SS_WORD7];
   assign serial_odd = st_ff.straps[bgrb_pkg::SS_ODD];
   assign serial_one_stop = st_ff.straps[bgrb_pkg::SS_ONE_STOP];
   assign serial_parity_on = st_ff.straps[bgrb_pkg::SS_PAR_ON];

   // checks on the bank's behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_step_wr;
      wr_hit_step;
   endsequence
   sequence s_cmd_wr;
      io_wr && io_addr == bgrb_pkg::ADR_PLANE_COMMAND;
   endsequence
   sequence s_status_rd;
      io_rd && io_addr == bgrb_pkg::ADR_BOARD_STATUS;
   endsequence
   sequence s_pix_wr;
      io_wr && io_addr == bgrb_pkg::ADR_PIXEL_DATA;
   endsequence
   sequence s_pix_rd;
      io_rd && io_addr == bgrb_pkg::ADR_PIXEL_DATA;
   endsequence

   property p_x_up;
      s_step_wr ##0 (io_wdata[bgrb_pkg::CS_X_UP] && !io_wdata[bgrb_pkg::CS_X_DOWN])
         |=> st_ff.x == $past(st_ff.x) + 16'h0001;
   endproperty
   a_x_up: assert property (p_x_up) else $error("x did not step up");

   property p_y_down;
      s_step_wr ##0 (io_wdata[bgrb_pkg::CS_Y_DOWN] && !io_wdata[bgrb_pkg::CS_Y_UP])
         |=> st_ff.y == $past(st_ff.y) - 16'h0001;
   endproperty
   a_y_down: assert property (p_y_down) else $error("y did not step down");

   property p_dot;
      s_step_wr ##0 (!io_wdata[bgrb_pkg::CS_NO_DOT] && st_ff.wen)
         |=> st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)] == $past(st_ff.data);
   endproperty
   a_dot: assert property (p_dot) else $error("dot not written at new pixel");

   property p_gate;
      !st_ff.wen && io_wr |=> st_ff.mem == $past(st_ff.mem);
   endproperty
   a_gate: assert property (p_gate) else $error("memory changed while gated");

   property p_format;
      s_cmd_wr |=> display_format == $past(io_wdata[7:6]) ##1
         ($stable(display_format) || $past(io_wr));
   endproperty
   a_format: assert property (p_format) else $error("format not loaded");

   property p_blank;
      st_ff.cmd[bgrb_pkg::PC_OFF0] ##1 st_ff.cmd[bgrb_pkg::PC_OFF0] |-> !vid_pixel[0];
   endproperty
   a_blank: assert property (p_blank) else $error("plane zero video not blanked");

   property p_status;
      s_status_rd |=> io_rdata[bgrb_pkg::BS_VBLANK_N] == $past(st_ff.vb_s2) &&
         io_rdata[bgrb_pkg::BS_WORD7] == $past(serial_word7) &&
         io_rdata[bgrb_pkg::BS_INPUT] == $past(st_ff.tin_flag) &&
         io_rdata[bgrb_pkg::BS_BUSY] == $past(st_ff.busy_s2);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

   property p_flag_set;
      term_rise |=> st_ff.tin_flag && st_ff.tin == $past(st_ff.td_s2);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("input flag not set");

   property p_flag_clr;
      io_rd && io_addr == bgrb_pkg::ADR_TERMINAL_INPUT && !term_rise |=> !st_ff.tin_flag;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("input flag not cleared");

   property p_printer;
      io_wr && io_addr == bgrb_pkg::ADR_PRINTER_OUT
         |=> printer_load && printer_data == $past(io_wdata) ##1
         (!printer_load || $past(io_wr));
   endproperty
   a_printer: assert property (p_printer) else $error("printer byte not forwarded");

   property p_x_down;
      s_step_wr ##0 (io_wdata[bgrb_pkg::CS_X_DOWN] && !io_wdata[bgrb_pkg::CS_X_UP])
         |=> st_ff.x == $past(st_ff.x) - 16'h0001;
   endproperty
   a_x_down: assert property (p_x_down) else $error("x did not step down");

   property p_y_up;
      s_step_wr ##0 (io_wdata[bgrb_pkg::CS_Y_UP] && !io_wdata[bgrb_pkg::CS_Y_DOWN])
         |=> st_ff.y == $past(st_ff.y) + 16'h0001;
   endproperty
   a_y_up: assert property (p_y_up) else $error("y did not step up");

   property p_step_cancel;
      s_step_wr ##0 (io_wdata[bgrb_pkg::CS_X_UP] && io_wdata[bgrb_pkg::CS_X_DOWN])
         |=> st_ff.x == $past(st_ff.x);
   endproperty
   a_step_cancel: assert property (p_step_cancel) else $error("x moved on cancel");

   property p_no_dot;
      s_step_wr ##0 io_wdata[bgrb_pkg::CS_NO_DOT] |=> st_ff.mem == $past(st_ff.mem);
   endproperty
   a_no_dot: assert property (p_no_dot) else $error("memory changed on step only");

   // fills checked at the addressed pixel, which a command write leaves in place
   property p_fill0;
      s_cmd_wr ##0 (io_wdata[bgrb_pkg::PC_FILL0] && st_ff.wen)
         |=> st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)][0] == $past(st_ff.data[0]);
   endproperty
   a_fill0: assert property (p_fill0) else $error("plane zero not filled");

   property p_fill1;
      s_cmd_wr ##0 (io_wdata[bgrb_pkg::PC_FILL1] && st_ff.wen)
         |=> st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)][1] == $past(st_ff.data[1]);
   endproperty
   a_fill1: assert property (p_fill1) else $error("plane one not filled");

   property p_blank1;
      st_ff.cmd[bgrb_pkg::PC_OFF1] ##1 st_ff.cmd[bgrb_pkg::PC_OFF1] |-> !vid_pixel[1];
   endproperty
   a_blank1: assert property (p_blank1) else $error("plane one video not blanked");

   property p_data_load;
      s_pix_wr |=> st_ff.data == $past(io_wdata[1:0]);
   endproperty
   a_data_load: assert property (p_data_load) else $error("data bits not loaded");

   // complement flips both planes at the current coordinates
   property p_comp;
      s_pix_wr ##0 (io_wdata[bgrb_pkg::PD_COMP] && st_ff.wen)
         |=> st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)] ==
         ~$past(st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)]);
   endproperty
   a_comp: assert property (p_comp) else $error("pixel not complemented");

   // pixel data read returns plane bits and the parity and stop straps
   property p_pix_read;
      s_pix_rd |=> io_rdata[1:0] == $past(st_ff.mem[bgrb_idx(st_ff.x, st_ff.y)]) &&
         io_rdata[4:2] == 3'h0 &&
         io_rdata[bgrb_pkg::PD_ODD] == $past(serial_odd) &&
         io_rdata[bgrb_pkg::PD_COMP] == $past(serial_one_stop) &&
         io_rdata[bgrb_pkg::PD_PAR_ON] == $past(serial_parity_on);
   endproperty
   a_pix_read: assert property (p_pix_read) else $error("pixel data read wrong");

   property p_straps;
      io_wr && io_addr == bgrb_pkg::ADR_SERIAL_STRAPS |=>
         {serial_parity_on, serial_one_stop, serial_odd, serial_word7} == $past(io_wdata[3:0]);
   endproperty
   a_straps: assert property (p_straps) else $error("straps wrong");

   property p_pan;
      io_wr && io_addr == bgrb_pkg::ADR_PAN_FINE |=> pan_fine == $past(io_wdata);
   endproperty
   a_pan: assert property (p_pan) else $error("fine pan not loaded");

   property p_pan_coarse;
      io_wr && io_addr == bgrb_pkg::ADR_PAN_COARSE |=> pan_coarse == $past(io_wdata);
   endproperty
   a_pan_coarse: assert property (p_pan_coarse) else $error("coarse pan not loaded");

   property p_coord_wr;
      io_wr && io_addr == bgrb_pkg::ADR_Y_HI |=> st_ff.y[15:8] == $past(io_wdata);
   endproperty
   a_coord_wr: assert property (p_coord_wr) else $error("y high byte not loaded");

   property p_coord_rd;
      io_rd && io_addr == bgrb_pkg::ADR_X_LO |=> io_rdata == $past(st_ff.x[7:0]);
   endproperty
   a_coord_rd: assert property (p_coord_rd) else $error("x low byte read wrong");

   property p_wen;
      io_wr && io_addr == bgrb_pkg::ADR_MEMORY_WRITE_GATE |=>
         st_ff.wen == $past(io_wdata[bgrb_pkg::WG_ENABLE]);
   endproperty
   a_wen: assert property (p_wen) else $error("write gate not loaded");

   // the input flag stands until the input byte is read
   property p_flag_hold;
      st_ff.tin_flag && !(io_rd && io_addr == bgrb_pkg::ADR_TERMINAL_INPUT) |=> st_ff.tin_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("input flag dropped");

   property p_load_src;
      printer_load |-> $past(io_wr && io_addr == bgrb_pkg::ADR_PRINTER_OUT);
   endproperty
   a_load_src: assert property (p_load_src) else $error("stray printer load");

endmodule : bgrb_register_bank

/* verif/bgrb_partner.sv */
// far-side model: printer busy pin, vertical blanking pin and terminal byte source
`timescale 1ns/1ps
module bgrb_partner (
   input wire logic ref_clk,
   input wire logic busy_req,
   input wire logic blank_req,
   input wire logic send,
   input wire logic [7:0] send_byte,
   output logic printer_busy,
   output logic vblank_n,
   output logic term_strobe,
   output logic [7:0] term_data,
   output logic link_idle
);
   initial
   begin
      printer_busy = 1'b0;
      vblank_n = 1'b1;
      term_strobe = 1'b0;
      term_data = 8'h5a;
      link_idle = 1'b1;
   end
   // printer and raster pins follow the bench requests
   always @(posedge ref_clk)
   begin
      printer_busy <= busy_req;
      vblank_n <= ~blank_req;
   end
   // one byte per strobe, held four clocks before the rise and four clocks after the fall
   always
   begin
      @(posedge ref_clk);
      if (send)
      begin
         link_idle <= 1'b0;
         term_data <= send_byte;
         repeat (4) @(posedge ref_clk);
         term_strobe <= 1'b1;
         repeat (4) @(posedge ref_clk);
         term_strobe <= 1'b0;
         repeat (4) @(posedge ref_clk);
         term_data <= ~send_byte;   // released lines show no stale byte
         link_idle <= 1'b1;
      end
   end
endmodule : bgrb_partner

/* verif/bgrb_register_bank_tb.sv */
// self-checking bench of the graphics register bank
`timescale 1ns/1ps
module bgrb_register_bank_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] io_addr = 8'h00;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [3:0] vid_x = 4'h0;
   logic [3:0] vid_y = 4'h0;
   logic busy_req = 1'b0;
   logic blank_req = 1'b0;
   logic send = 1'b0;
   logic [7:0] send_byte = 8'h00;
   logic rd_q = 1'b0;
   logic [7:0] io_rdata, pan_fine, pan_coarse, scroll_top_row, magnify_factors, printer_data;
   logic [7:0] term_data, b;
   logic [1:0] vid_pixel, display_format;
   logic printer_busy, vblank_n, term_strobe, printer_load, link_idle;
   logic serial_word7, serial_odd, serial_one_stop, serial_parity_on;
   logic [3:0] straps_out;
   logic [7:0] rq[$];
   logic [7:0] pq[$];
   logic [31:0] rnd = 32'hd8b9;
   int err_total = 0;
   int checks = 0;
   assign straps_out = {serial_parity_on, serial_one_stop, serial_odd, serial_word7};
   bgrb_register_bank #(.PIX_X_W(4), .PIX_Y_W(4)) bgrb_register_bank_inst (
      .ref_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .printer_busy,
      .vblank_n, .term_strobe, .term_data, .vid_x, .vid_y, .vid_pixel, .display_format,
      .pan_fine, .pan_coarse, .scroll_top_row, .magnify_factors, .printer_data,
      .printer_load, .serial_word7, .serial_odd, .serial_one_stop, .serial_parity_on);
   bgrb_partner bgrb_partner_inst (.ref_clk, .busy_req, .blank_req, .send, .send_byte,
      .printer_busy, .vblank_n, .term_strobe, .term_data, .link_idle);
   // 25 ns clock
   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] step_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : step_rnd
   // pixel data read once all four strap bits are set
   function automatic logic [7:0] pd(input logic [1:0] p);
      return {3'h7, 3'h0, p};
   endfunction : pd
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp
   task automatic complete_run;
      if (err_total == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge ref_clk);
      io_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      rq.push_back(e);
      @(posedge ref_clk);
      io_rd <= 1'b0;
   endtask : rd
   task automatic chk_vid(input logic [3:0] x, input logic [3:0] y, input logic [1:0] e);
      @(posedge ref_clk);
      vid_x <= x;
      vid_y <= y;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp({6'h0, vid_pixel}, {6'h0, e});
   endtask : chk_vid
   // hands one byte to the terminal model and waits for its frame to end
   task automatic deposit(input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      send <= 1'b1;
      send_byte <= d;
      @(posedge ref_clk);
      send <= 1'b0;
      @(posedge ref_clk);
      for (n = 0; n < 64 && link_idle !== 1'b1; n++)
         @(posedge ref_clk);
      if (n == 64)
      begin
         err_total++;
         complete_run();
      end
   endtask : deposit
   // each result takes the oldest note off its queue
   always @(posedge ref_clk)
      rd_q <= io_rd;
   always @(negedge ref_clk)
   begin
      if (rd_q)
         cmp(rq.size() > 0 ? rq.pop_front() : 8'hxx, io_rdata);
      if (printer_load === 1'b1)
         cmp(pq.size() > 0 ? pq.pop_front() : 8'hxx, printer_data);
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      complete_run();
   end
   // main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      cmp({2'h0, display_format, straps_out}, 8'h00);
      cmp(pan_fine | pan_coarse | scroll_top_row | magnify_factors | printer_data, 8'h00);
      chk_vid(4'h3, 4'h2, 2'h0);
      for (int i = 0; i < 4; i++)
         rd(8'h40 + 8'(i), 8'h00);
      // strap fields seen at outputs, status and pixel data
      for (int i = 0; i < 16; i++)
      begin
         rnd = step_rnd(rnd);
         b = {rnd[7:4], 4'(i)};
         wr(8'h30, b);
         @(negedge ref_clk);
         cmp({4'h0, straps_out}, {4'h0, b[3:0]});
         rd(8'ha0, {5'h0, b[0], 2'h2});
         rd(8'h68, {b[3:1], 5'h0});
      end
      // dot writes and steps, first with the gate closed
      wr(8'h68, 8'h03);
      wr(8'h60, 8'h00);
      rd(8'h68, pd(2'h0));
      wr(8'ha3, 8'h01);
      wr(8'h60, 8'h01);
      rd(8'h40, 8'h01);
      rd(8'h68, pd(2'h3));
      wr(8'h60, 8'h12);
      rd(8'h42, 8'h01);
      rd(8'h68, pd(2'h0));
      wr(8'h60, 8'h0a);
      rd(8'h68, pd(2'h3));
      wr(8'h60, 8'h18);
      wr(8'h68, 8'h40);
      rd(8'h68, pd(2'h0));
      wr(8'h60, 8'h14);
      wr(8'h60, 8'h14);
      rd(8'h41, 8'hff);
      wr(8'h40, 8'h01);
      wr(8'h41, 8'h00);
      rd(8'h41, 8'h00);
      // plane fills, video blanking, then fill and complement with the gate closed
      wr(8'h68, 8'h03);
      wr(8'h62, 8'h03);
      rd(8'h68, pd(2'h3));
      chk_vid(4'h9, 4'h6, 2'h3);
      wr(8'h62, 8'h10);
      chk_vid(4'h9, 4'h6, 2'h2);
      wr(8'h62, 8'h20);
      chk_vid(4'h9, 4'h6, 2'h1);
      wr(8'ha3, 8'h00);
      wr(8'h68, 8'h42);
      wr(8'h62, 8'h03);
      rd(8'h68, pd(2'h3));
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h62, {2'(k), 6'h00});
         @(negedge ref_clk);
         cmp({6'h0, display_format}, {6'h0, 2'(k)});
      end
      // fine pan stepped, coarse pan advanced inside blanking
      for (int c = 1; c < 3; c++)
      begin
         for (int f = 0; f < 10; f++)
            wr(8'h64, 8'(f));
         blank_req <= 1'b1;
         repeat (4) @(posedge ref_clk);
         rd(8'ha0, 8'h04);
         wr(8'h65, 8'(c));
         blank_req <= 1'b0;
         @(negedge ref_clk);
         cmp(pan_coarse, 8'(c));
      end
      wr(8'h64, 8'h79);
      @(negedge ref_clk);
      cmp(pan_fine, 8'h79);
      wr(8'h62, 8'h40);
      wr(8'h66, 8'h02);
      rnd = step_rnd(rnd);
      wr(8'h67, rnd[7:0]);
      @(negedge ref_clk);
      cmp(scroll_top_row, 8'h02);
      cmp(magnify_factors, rnd[7:0]);
      // printer bytes, busy line in status
      for (int i = 0; i < 3; i++)
      begin
         rnd = step_rnd(rnd);
         pq.push_back(rnd[7:0]);
         wr(8'ha1, rnd[7:0]);
      end
      busy_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(8'ha0, 8'h07);
      cmp(8'(pq.size()), 8'h00);
      busy_req <= 1'b0;
      // second byte overwrites the unread first; reading clears the flag
      rnd = step_rnd(rnd);
      deposit(~rnd[7:0]);
      deposit(rnd[7:0]);
      rd(8'ha0, 8'h86);
      rd(8'ha2, rnd[7:0]);
      rd(8'ha0, 8'h06);
      wr(8'h01, 8'hff);
      rd(8'h00, 8'h00);
      repeat (4) @(posedge ref_clk);
      cmp(8'(rq.size()), 8'h00);
      complete_run();
   end
endmodule : bgrb_register_bank_tb
